// *** rtl/cie_core.sv ***
// instruction execute core with avalon-mm register access
//
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps

module cie_core
	import cie_pkg::*;
#(
	parameter int PC_WIDTH    = PC_WIDTH_DEF,
	parameter int STACK_DEPTH = STACK_DEPTH_DEF
)(
	input  wire logic                CLOCK,
	input  wire logic                RST,
	input  wire logic [5:0]          AVS_ADDRESS,
	input  wire logic                AVS_READ,
	input  wire logic                AVS_WRITE,
	input  wire logic [3:0]          AVS_BYTEENABLE,
	input  wire logic [31:0]         AVS_WRITEDATA,
	output logic      [31:0]         AVS_READDATA,
	output logic                     AVS_WAITREQUEST,
	output logic      [PC_WIDTH-1:0] PROG_ADDR,
	input  wire logic [15:0]         PROG_DATA,
	output logic                     SLEEP_ACTIVE,
	output logic                     GLOBAL_INT_EN
);

	localparam int SPW = $clog2(STACK_DEPTH);
	localparam int HPW = PC_WIDTH - 8;

	generate
		if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0 ||
		    PC_WIDTH < 9 || PC_WIDTH > 16) begin : g_bad_params
			$error("cie_core: stack depth must be a power of two, pc width 9 to 16");
		end
	endgenerate

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_EXEC,
		ST_SECOND,
		ST_SLEEP
	} cie_phase_type;

	typedef struct packed {
		cie_phase_type                       phase;
		logic [PC_WIDTH-1:0]                 pc;
		logic [PC_WIDTH-1:0]                 prog_addr;
		logic [15:0]                         ir;
		logic [7:0]                          acc;
		logic                                carry;
		logic                                digit_carry;
		logic                                zero;
		logic                                powerdown_status;
		logic                                timeout_status;
		logic                                global_interrupt_enable;
		logic                                unsupported;
		logic                                run;
		logic                                ack;
		logic                                osc_stop;
		logic [HPW-1:0]                      table_pointer_high;
		logic [7:0]                          table_pointer_low;
		logic [STACK_DEPTH-1:0][PC_WIDTH-1:0] stack;
		logic [SPW-1:0]                      sp;
		logic [FILE_AWIDTH-1:0]              file_sel;
		logic [31:0]                         rdata;
	} cie_state_type;

	cie_state_type          state_reg;
	cie_state_type          state_next;
	logic [7:0]             file_mem [0:FILE_WORDS-1];
	logic                   fw_en;
	logic [FILE_AWIDTH-1:0] fw_addr;
	logic [7:0]             fw_data;
	logic [FILE_AWIDTH-1:0] f_addr;
	logic                   dest_reg_sel;
	logic [7:0]             f_val;
	logic [7:0]             k_val;
	logic [SPW-1:0]         sp_dec;
	logic [PC_WIDTH-1:0]    stack_top;
	logic [10:0]            lit_sub;
	logic [10:0]            reg_sub;
	logic [5:0]             bus_word;
	logic [31:0]            rd_mux;
	logic                   halted;
	logic                   bus_wr;
	logic                   has_dest;
	logic                   unsup_set;
	logic [7:0]             result;

	// returns {carry, digit_carry, zero, difference}; carry high means no borrow
	function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] d;
		logic [4:0] l;
		begin
			d = {1'b0, a} - {1'b0, b};
			l = {1'b0, a[3:0]} - {1'b0, b[3:0]};
			sub8 = {~d[8], ~l[4], d[7:0] == 8'h00, d[7:0]};
		end
	endfunction : sub8

	// after an instruction: fetch the next one, or park if software cleared run
	function automatic cie_state_type advance(input cie_state_type v);
		begin
			advance = v;
			if (v.run) begin
				advance.phase = ST_FETCH;
				advance.prog_addr = v.pc;
			end else begin
				advance.phase = ST_IDLE;
			end
		end
	endfunction : advance

	assign f_addr       = {state_reg.ir[15:14], state_reg.ir[6:0]};
	assign dest_reg_sel = state_reg.ir[7];
	assign f_val        = file_mem[f_addr];
	assign k_val        = state_reg.ir[7:0];
	assign sp_dec       = state_reg.sp - 1'b1;
	assign stack_top    = state_reg.stack[sp_dec];
	assign lit_sub      = sub8(k_val, state_reg.acc);
	assign reg_sub      = sub8(f_val, state_reg.acc);
	assign bus_word     = {AVS_ADDRESS[5:2], 2'b00};
	assign halted       = (state_reg.phase == ST_IDLE);
	assign bus_wr       = AVS_WRITE & state_reg.ack;

	// every access waits exactly one cycle so read data can come from a flop
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~state_reg.ack;
	assign AVS_READDATA    = state_reg.rdata;
	assign PROG_ADDR       = state_reg.prog_addr;
	assign SLEEP_ACTIVE    = state_reg.osc_stop;
	assign GLOBAL_INT_EN   = state_reg.global_interrupt_enable;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (bus_word)
			OFF_CONTROL: begin
				rd_mux[CTRL_RUN_POS] = state_reg.run;
			end
			OFF_STATUS: begin
				rd_mux[STAT_CARRY_POS]       = state_reg.carry;
				rd_mux[STAT_DIGIT_CARRY_POS] = state_reg.digit_carry;
				rd_mux[STAT_ZERO_POS]        = state_reg.zero;
				rd_mux[STAT_POWERDOWN_POS]   = state_reg.powerdown_status;
				rd_mux[STAT_TIMEOUT_POS]     = state_reg.timeout_status;
				rd_mux[STAT_GLOBAL_IE_POS]   = state_reg.global_interrupt_enable;
				rd_mux[STAT_SLEEPING_POS]    = state_reg.osc_stop;
				rd_mux[STAT_BUSY_POS]        = ~halted;
				rd_mux[STAT_UNSUPPORTED_POS] = state_reg.unsupported;
			end
			OFF_ACC: begin
				rd_mux[7:0] = state_reg.acc;
			end
			OFF_PC: begin
				rd_mux[PC_WIDTH-1:0] = state_reg.pc;
			end
			OFF_TPTR: begin
				rd_mux[7:0]          = state_reg.table_pointer_low;
				rd_mux[PC_WIDTH-1:8] = state_reg.table_pointer_high;
			end
			OFF_STACK: begin
				rd_mux[PC_WIDTH-1:0]           = stack_top;
				rd_mux[STACK_PTR_POS +: SPW]   = state_reg.sp;
			end
			OFF_FILE_SEL: begin
				rd_mux[FILE_AWIDTH-1:0] = state_reg.file_sel;
			end
			OFF_FILE_DATA: begin
				rd_mux[7:0] = file_mem[state_reg.file_sel];
			end
			OFF_OPCODE: begin
				rd_mux[15:0] = state_reg.ir;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	always_comb begin
		state_next = state_reg;
		fw_en      = 1'b0;
		fw_addr    = f_addr;
		fw_data    = 8'h00;
		has_dest   = 1'b0;
		unsup_set  = 1'b0;
		result     = 8'h00;

		state_next.ack = (AVS_READ | AVS_WRITE) & ~state_reg.ack;
		if (AVS_READ & ~state_reg.ack) begin
			state_next.rdata = rd_mux;
		end

		case (state_reg.phase)
			ST_IDLE: begin
				state_next = advance(state_next);
			end
			ST_FETCH: begin
				state_next.ir = PROG_DATA;
				state_next.pc = state_reg.pc + 1'b1;
				state_next.phase = ST_EXEC;
			end
			ST_EXEC: begin
				state_next = advance(state_next);
				if (state_reg.ir == OP_NO_OPERATION) begin
					state_next.phase = state_next.phase;
				end else if (state_reg.ir == OP_RETURN_SUBROUTINE ||
				             state_reg.ir == OP_RETURN_INTERRUPT) begin
					state_next.pc    = stack_top;
					state_next.sp    = sp_dec;
					state_next.phase = ST_SECOND;
					if (state_reg.ir == OP_RETURN_INTERRUPT) begin
						state_next.global_interrupt_enable = 1'b1;
					end
				end else if (state_reg.ir == OP_TABLE_READ_LOW ||
				             state_reg.ir == OP_TABLE_READ_HIGH) begin
					// program port is borrowed for the table word in the second cycle
					state_next.prog_addr = {state_reg.table_pointer_high,
					                        state_reg.table_pointer_low};
					state_next.phase     = ST_SECOND;
				end else if (state_reg.ir == OP_SLEEP) begin
					state_next.timeout_status   = 1'b1;
					state_next.powerdown_status = 1'b0;
					state_next.phase            = ST_SLEEP;
				end else if (state_reg.ir[15:12] == GRP_LITERAL) begin
					case (state_reg.ir[11:8])
						LIT_LOAD: begin
							state_next.acc = k_val;
						end
						LIT_RETURN_LITERAL: begin
							state_next.acc   = k_val;
							state_next.pc    = stack_top;
							state_next.sp    = sp_dec;
							state_next.phase = ST_SECOND;
						end
						LIT_SUBTRACT: begin
							state_next.acc         = lit_sub[7:0];
							state_next.zero        = lit_sub[8];
							state_next.digit_carry = lit_sub[9];
							state_next.carry       = lit_sub[10];
						end
						LIT_XOR: begin
							state_next.acc  = state_reg.acc ^ k_val;
							state_next.zero = (state_reg.acc ^ k_val) == 8'h00;
						end
						default: begin
							unsup_set = 1'b1;
						end
					endcase
				end else if (state_reg.ir[13:12] == GRP_REGISTER) begin
					case (state_reg.ir[11:8])
						REG_MOVE: begin
							state_next.zero = (f_val == 8'h00);
							if (!dest_reg_sel) begin
								state_next.acc = f_val;
							end
						end
						REG_STORE: begin
							if (dest_reg_sel) begin
								fw_en   = 1'b1;
								fw_data = state_reg.acc;
							end else begin
								unsup_set = 1'b1;
							end
						end
						REG_ROT_L: begin
							result           = {f_val[6:0], state_reg.carry};
							state_next.carry = f_val[7];
							has_dest         = 1'b1;
						end
						REG_ROT_R: begin
							result           = {state_reg.carry, f_val[7:1]};
							state_next.carry = f_val[0];
							has_dest         = 1'b1;
						end
						REG_SUBTRACT: begin
							result                 = reg_sub[7:0];
							state_next.zero        = reg_sub[8];
							state_next.digit_carry = reg_sub[9];
							state_next.carry       = reg_sub[10];
							has_dest               = 1'b1;
						end
						REG_SWAP: begin
							result   = {f_val[3:0], f_val[7:4]};
							has_dest = 1'b1;
						end
						REG_XOR: begin
							result          = state_reg.acc ^ f_val;
							state_next.zero = (result == 8'h00);
							has_dest        = 1'b1;
						end
						default: begin
							unsup_set = 1'b1;
						end
					endcase
				end else begin
					unsup_set = 1'b1;
				end
				if (has_dest) begin
					if (dest_reg_sel) begin
						fw_en   = 1'b1;
						fw_data = result;
					end else begin
						state_next.acc = result;
					end
				end
			end
			ST_SECOND: begin
				if (state_reg.ir == OP_TABLE_READ_HIGH) begin
					state_next.acc = PROG_DATA[15:8];
				end else if (state_reg.ir == OP_TABLE_READ_LOW) begin
					state_next.acc = PROG_DATA[7:0];
				end
				state_next = advance(state_next);
			end
			ST_SLEEP: begin
				state_next.phase = ST_SLEEP;
			end
			default: begin
				state_next.phase = ST_IDLE;
			end
		endcase

		if (unsup_set) begin
			state_next.unsupported = 1'b1;
		end

		// core state other than run, wake, file select and the unsupported clear is only writable while parked, so the core never races software on it
		if (bus_wr) begin
			case (bus_word)
				OFF_CONTROL: begin
					if (AVS_BYTEENABLE[0]) begin
						state_next.run = AVS_WRITEDATA[CTRL_RUN_POS];
						if (AVS_WRITEDATA[CTRL_WAKE_POS] && state_reg.phase == ST_SLEEP) begin
							state_next.phase = ST_IDLE;
						end
					end
				end
				OFF_STATUS: begin
					if (AVS_BYTEENABLE[0] && halted) begin
						state_next.carry       = AVS_WRITEDATA[STAT_CARRY_POS];
						state_next.digit_carry = AVS_WRITEDATA[STAT_DIGIT_CARRY_POS];
						state_next.zero        = AVS_WRITEDATA[STAT_ZERO_POS];
						state_next.global_interrupt_enable =
							AVS_WRITEDATA[STAT_GLOBAL_IE_POS];
					end
					// a new unsupported opcode in the same cycle beats the clear
					if (AVS_BYTEENABLE[1] && AVS_WRITEDATA[STAT_UNSUPPORTED_POS] &&
					    !unsup_set) begin
						state_next.unsupported = 1'b0;
					end
				end
				OFF_ACC: begin
					if (AVS_BYTEENABLE[0] && halted) begin
						state_next.acc = AVS_WRITEDATA[7:0];
					end
				end
				OFF_PC: begin
					if (AVS_BYTEENABLE[1:0] == 2'b11 && halted) begin
						state_next.pc = AVS_WRITEDATA[PC_WIDTH-1:0];
					end
				end
				OFF_TPTR: begin
					if (AVS_BYTEENABLE[0] && halted) begin
						state_next.table_pointer_low = AVS_WRITEDATA[7:0];
					end
					if (AVS_BYTEENABLE[1] && halted) begin
						state_next.table_pointer_high = AVS_WRITEDATA[PC_WIDTH-1:8];
					end
				end
				OFF_STACK: begin
					// push only; the stack wraps silently when overfilled
					if (AVS_BYTEENABLE[1:0] == 2'b11 && halted) begin
						state_next.stack[state_reg.sp] = AVS_WRITEDATA[PC_WIDTH-1:0];
						state_next.sp = state_reg.sp + 1'b1;
					end
				end
				OFF_FILE_SEL: begin
					if (AVS_BYTEENABLE[1:0] == 2'b11) begin
						state_next.file_sel = AVS_WRITEDATA[FILE_AWIDTH-1:0];
					end
				end
				OFF_FILE_DATA: begin
					if (AVS_BYTEENABLE[0] && halted) begin
						fw_en   = 1'b1;
						fw_addr = state_reg.file_sel;
						fw_data = AVS_WRITEDATA[7:0];
					end
				end
				default: begin
					state_next.run = state_next.run;
				end
			endcase
		end

		state_next.osc_stop = (state_next.phase == ST_SLEEP);
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			state_reg <= '0;
			state_reg.acc <= RST_ACC;
			state_reg.timeout_status <= RST_TIMEOUT_STATUS;
			state_reg.powerdown_status <= RST_POWERDOWN_STATUS;
			state_reg.global_interrupt_enable <= RST_GLOBAL_IE;
		end else begin
			state_reg <= state_next;
		end
	end

	// data file has no reset; software loads it through the bus
	always_ff @(posedge CLOCK) begin
		if (fw_en) begin
			file_mem[fw_addr] <= fw_data;
		end
	end

endmodule : cie_core

// *** include/cie_pkg.sv ***
// constants, offsets and opcodes of the instruction execute core
package cie_pkg;

	// default sizes
	localparam int PC_WIDTH_DEF    = 13;
	localparam int STACK_DEPTH_DEF = 8;
	localparam int FILE_AWIDTH     = 9;
	localparam int FILE_WORDS      = 512;

	// register byte offsets on the bus
	localparam logic [5:0] OFF_CONTROL   = 6'h00;
	localparam logic [5:0] OFF_STATUS    = 6'h04;
	localparam logic [5:0] OFF_ACC       = 6'h08;
	localparam logic [5:0] OFF_PC        = 6'h0C;
	localparam logic [5:0] OFF_TPTR      = 6'h10;
	localparam logic [5:0] OFF_STACK     = 6'h14;
	localparam logic [5:0] OFF_FILE_SEL  = 6'h18;
	localparam logic [5:0] OFF_FILE_DATA = 6'h1C;
	localparam logic [5:0] OFF_OPCODE    = 6'h20;

	// control fields
	localparam int CTRL_RUN_POS  = 0;
	localparam int CTRL_WAKE_POS = 1;

	// status fields
	localparam int STAT_CARRY_POS       = 0;
	localparam int STAT_DIGIT_CARRY_POS = 1;
	localparam int STAT_ZERO_POS        = 2;
	localparam int STAT_POWERDOWN_POS   = 3;
	localparam int STAT_TIMEOUT_POS     = 4;
	localparam int STAT_GLOBAL_IE_POS   = 5;
	localparam int STAT_SLEEPING_POS    = 6;
	localparam int STAT_BUSY_POS        = 7;
	localparam int STAT_UNSUPPORTED_POS = 8;

	// stack register: level pointer field
	localparam int STACK_PTR_POS = 16;

	// whole-word opcodes
	localparam logic [15:0] OP_NO_OPERATION      = 16'h0000;
	localparam logic [15:0] OP_RETURN_SUBROUTINE = 16'h0040;
	localparam logic [15:0] OP_RETURN_INTERRUPT  = 16'h0060;
	localparam logic [15:0] OP_TABLE_READ_LOW    = 16'h0050;
	localparam logic [15:0] OP_TABLE_READ_HIGH   = 16'h0058;
	localparam logic [15:0] OP_SLEEP             = 16'h1E03;

	// literal group: bits 15:12 then bits 11:8
	localparam logic [3:0] GRP_LITERAL        = 4'h1;
	localparam logic [3:0] LIT_RETURN_LITERAL = 4'h8;
	localparam logic [3:0] LIT_LOAD           = 4'h9;
	localparam logic [3:0] LIT_XOR            = 4'hD;
	localparam logic [3:0] LIT_SUBTRACT       = 4'hF;

	// register group: bits 13:12 zero, bits 11:8
	localparam logic [1:0] GRP_REGISTER = 2'h0;
	localparam logic [3:0] REG_STORE    = 4'h0;
	localparam logic [3:0] REG_SUBTRACT = 4'h2;
	localparam logic [3:0] REG_XOR      = 4'h6;
	localparam logic [3:0] REG_MOVE     = 4'h8;
	localparam logic [3:0] REG_ROT_R    = 4'hC;
	localparam logic [3:0] REG_ROT_L    = 4'hD;
	localparam logic [3:0] REG_SWAP     = 4'hE;

	// reset values
	localparam logic [7:0] RST_ACC              = 8'h00;
	localparam logic       RST_TIMEOUT_STATUS   = 1'h1;
	localparam logic       RST_POWERDOWN_STATUS = 1'h1;
	localparam logic       RST_GLOBAL_IE        = 1'h0;

endpackage : cie_pkg

// *** verif/cie_prog_mem.sv ***
// combinational program memory on the far side of the fetch port
`timescale 1ns/10ps
module cie_prog_mem
	import cie_pkg::*;
#(
	parameter int PC_WIDTH = PC_WIDTH_DEF
)(
	input  wire logic [PC_WIDTH-1:0] PROG_ADDR,
	output logic      [15:0]         PROG_DATA
);
	logic [15:0] mem_reg [0:(1<<PC_WIDTH)-1];

	// words never loaded hold a shifting pattern, so no fetch sees a stale value
	initial begin
		for (int i = 0; i < (1 << PC_WIDTH); i++)
			mem_reg[i] = 16'hA5C3 ^ 16'(i * 16'h0107);
	end

	assign PROG_DATA = mem_reg[PROG_ADDR];
endmodule : cie_prog_mem

// *** verif/cie_core_props.sv ***
// port checks of the execute core: bus handshake, sleep and interrupt enable
`timescale 1ns/10ps
module cie_core_props
	import cie_pkg::*;
#(
	parameter int PC_WIDTH = PC_WIDTH_DEF
)(
	input wire logic                CLOCK,
	input wire logic                RST,
	input wire logic [5:0]          AVS_ADDRESS,
	input wire logic                AVS_READ,
	input wire logic                AVS_WRITE,
	input wire logic [3:0]          AVS_BYTEENABLE,
	input wire logic [31:0]         AVS_WRITEDATA,
	input wire logic [31:0]         AVS_READDATA,
	input wire logic                AVS_WAITREQUEST,
	input wire logic [PC_WIDTH-1:0] PROG_ADDR,
	input wire logic [15:0]         PROG_DATA,
	input wire logic                SLEEP_ACTIVE,
	input wire logic                GLOBAL_INT_EN
);
	logic req;
	logic wake_ack;
	logic stat_wr;

	assign req = AVS_READ || AVS_WRITE;
	assign wake_ack = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[5:2] == OFF_CONTROL[5:2]
		&& AVS_BYTEENABLE[0] && AVS_WRITEDATA[CTRL_WAKE_POS];
	assign stat_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[5:2] == OFF_STATUS[5:2]
		&& AVS_BYTEENABLE[0];

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	sequence s_ack;
		req && !AVS_WAITREQUEST;
	endsequence
	sequence s_one_wait;
		AVS_WAITREQUEST ##1 s_ack;
	endsequence

	a_reset_quiet: assert property (disable iff (1'b0) RST |=> PROG_ADDR == '0
		&& !SLEEP_ACTIVE && !GLOBAL_INT_EN && AVS_READDATA == 32'h0)
		else $error("outputs not cleared by reset");
	a_wait_first: assert property ($rose(req) |-> s_one_wait)
		else $error("request not answered after exactly one wait cycle");
	a_wait_once: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("waitrequest held beyond one cycle");
	a_rdata_hold: assert property (!AVS_READ |=> $stable(AVS_READDATA))
		else $error("read data changed without a read");
	a_sleep_entry: assert property ($rose(SLEEP_ACTIVE) |->
		$past(PROG_DATA, 2) == OP_SLEEP || $past(PROG_DATA, 3) == OP_SLEEP)
		else $error("sleep entered without a sleep word");
	a_sleep_hold: assert property (SLEEP_ACTIVE && !wake_ack |=>
		SLEEP_ACTIVE && $stable(PROG_ADDR))
		else $error("sleep left or fetch moved without wake");
	a_wake_exit: assert property (SLEEP_ACTIVE && wake_ack |-> ##[1:3] !SLEEP_ACTIVE)
		else $error("wake write did not end sleep");
	a_inten_rise: assert property ($rose(GLOBAL_INT_EN) |-> $past(stat_wr)
		|| $past(PROG_DATA, 1) == OP_RETURN_INTERRUPT
		|| $past(PROG_DATA, 2) == OP_RETURN_INTERRUPT
		|| $past(PROG_DATA, 3) == OP_RETURN_INTERRUPT)
		else $error("interrupt enable rose without cause");
	a_inten_fall: assert property ($fell(GLOBAL_INT_EN) |-> $past(stat_wr))
		else $error("interrupt enable fell without status write");
endmodule : cie_core_props

bind cie_core cie_core_props #(.PC_WIDTH(PC_WIDTH)) u_cie_core_props (
	.CLOCK(CLOCK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PROG_ADDR(PROG_ADDR),
	.PROG_DATA(PROG_DATA), .SLEEP_ACTIVE(SLEEP_ACTIVE), .GLOBAL_INT_EN(GLOBAL_INT_EN)
);

// *** verif/tb_cie_core.sv ***
// bench: steps the core one instruction at a time against a behavioural model
`timescale 1ns/10ps
module tb_cie_core
	import cie_pkg::*;
;
	logic        CLOCK = 1'b0;
	logic        RST = 1'b1;
	logic [5:0]  AVS_ADDRESS = 6'h00;
	logic        AVS_READ = 1'b0;
	logic        AVS_WRITE = 1'b0;
	logic [3:0]  AVS_BYTEENABLE = 4'h0;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic [31:0] AVS_READDATA, rd;
	logic        AVS_WAITREQUEST, SLEEP_ACTIVE, GLOBAL_INT_EN;
	logic [12:0] PROG_ADDR;
	logic [15:0] PROG_DATA, w;
	logic [3:0]  op;
	int          errors = 0;
	int          tests_run = 0;
	int          seed = 32'hA095;
	int          pdn = 1, tmo = 1, pc = 0;
	int          acc, fc, fdc, fz, ie_exp, f, res, a, d, k;
	int          file_m [512];
	int          stk [$];
	logic [3:0]  reg_ops [7] = '{REG_STORE, REG_SUBTRACT, REG_XOR, REG_MOVE, REG_ROT_R,
		REG_ROT_L, REG_SWAP};
	logic [3:0]  lit_ops [4] = '{LIT_LOAD, LIT_XOR, LIT_SUBTRACT, LIT_RETURN_LITERAL};
	logic [15:0] word_ops [5] = '{OP_NO_OPERATION, OP_RETURN_SUBROUTINE,
		OP_RETURN_INTERRUPT, OP_TABLE_READ_LOW, OP_TABLE_READ_HIGH};

	always #25 CLOCK = ~CLOCK;

	cie_core u_cie_core (
		.CLOCK(CLOCK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA),
		.SLEEP_ACTIVE(SLEEP_ACTIVE), .GLOBAL_INT_EN(GLOBAL_INT_EN)
	);
	cie_prog_mem u_cie_prog_mem (.PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA));

	task automatic finish_test;
		if (errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	// request is left standing on return so run and stop writes chain with no gap
	task automatic bus(input logic wr, input logic [5:0] adr, input int dat,
		input logic [3:0] be);
		logic ok;
		ok = 1'b0;
		AVS_ADDRESS <= adr;
		AVS_WRITEDATA <= 32'(dat);
		AVS_BYTEENABLE <= be;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		for (int n = 0; n < 20 && !ok; n++) begin
			@(posedge CLOCK);
			// values seen here are those before this edge, as the slave samples them
			ok = AVS_WAITREQUEST === 1'b0;
			if (ok && !wr)
				rd = AVS_READDATA;
		end
		if (!ok) begin
			check(32'h0, 32'h1);
			finish_test();
		end
	endtask : bus

	task automatic idle(input int n);
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		repeat (n) @(posedge CLOCK);
	endtask : idle

	task automatic load_state;
		bus(1'b1, OFF_FILE_SEL, a, 4'h3);
		bus(1'b1, OFF_FILE_DATA, file_m[a], 4'h1);
		bus(1'b1, OFF_ACC, acc, 4'h1);
		bus(1'b1, OFF_STATUS, fc | fdc << 1 | fz << 2 | ie_exp << 5, 4'h1);
	endtask : load_state

	task automatic run_one(input logic [15:0] wd);
		u_cie_prog_mem.mem_reg[pc] = wd;
		bus(1'b1, OFF_CONTROL, 32'h1, 4'h1);
		bus(1'b1, OFF_CONTROL, 32'h0, 4'h1);
	endtask : run_one

	task automatic verify;
		rd = 32'h80;
		for (int n = 0; n < 20 && rd[STAT_BUSY_POS] !== 1'b0; n++)
			bus(1'b0, OFF_STATUS, 32'h0, 4'hF);
		check(rd & 32'h1FF, 32'(fc | fdc << 1 | fz << 2 | pdn << 3 | tmo << 4 | ie_exp << 5));
		if (rd[STAT_BUSY_POS] !== 1'b0)
			finish_test();
		bus(1'b0, OFF_ACC, 32'h0, 4'hF);
		check(rd & 32'hFF, 32'(acc));
		bus(1'b0, OFF_PC, 32'h0, 4'hF);
		check(rd & 32'h1FFF, 32'(pc));
		bus(1'b1, OFF_FILE_SEL, a, 4'h3);
		bus(1'b0, OFF_FILE_DATA, 32'h0, 4'hF);
		check(rd & 32'hFF, 32'(file_m[a]));
		check(32'(GLOBAL_INT_EN), 32'(ie_exp));
		idle(1);
	endtask : verify

	task automatic rand_flags;
		k = $random(seed);
		fc = k & 1;
		fdc = k >> 1 & 1;
		fz = k >> 2 & 1;
		ie_exp = k >> 3 & 1;
	endtask : rand_flags

	initial begin
		repeat (20) @(posedge CLOCK);
		RST <= 1'b0;
		@(posedge CLOCK);
		bus(1'b0, OFF_STATUS, 32'h0, 4'hF);
		check(rd & 32'h1FF, 32'h18);
		bus(1'b1, 6'h24, 32'hFFFF_FFFF, 4'hF);
		bus(1'b0, 6'h24, 32'h0, 4'hF);
		check(rd, 32'h0);
		idle(1);
		for (int i = 0; i < 42; i++) begin
			op = reg_ops[i % 7];
			a = i < 2 ? i * 9'h1FF : $random(seed) & 9'h1FF;
			d = op == REG_STORE ? 1 : $random(seed) & 1;
			file_m[a] = i % 3 == 0 ? 0 : $random(seed) & 8'hFF;
			acc = i % 5 == 0 ? file_m[a] : $random(seed) & 8'hFF;
			rand_flags();
			load_state();
			f = file_m[a];
			run_one({a[8:7], 2'b00, op, d[0], a[6:0]});
			case (op)
				REG_STORE: res = acc;
				REG_SWAP: res = (f << 4 | f >> 4) & 8'hFF;
				REG_XOR: begin
					res = f ^ acc;
					fz = res == 0;
				end
				REG_MOVE: begin
					res = f;
					fz = f == 0;
				end
				REG_ROT_R: begin
					res = fc << 7 | f >> 1;
					fc = f & 1;
				end
				REG_ROT_L: begin
					res = (f << 1 | fc) & 8'hFF;
					fc = f >> 7;
				end
				default: begin
					res = (f - acc) & 8'hFF;
					fc = f >= acc;
					fdc = (f & 8'h0F) >= (acc & 8'h0F);
					fz = res == 0;
				end
			endcase
			if (d == 1)
				file_m[a] = res;
			else
				acc = res;
			pc = (pc + 1) & 13'h1FFF;
			verify();
		end
		for (int i = 0; i < 16; i++) begin
			op = lit_ops[i % 4];
			k = i < 4 ? 0 : $random(seed) & 8'hFF;
			acc = i < 4 ? 0 : $random(seed) & 8'hFF;
			res = k;
			rand_flags();
			load_state();
			if (op == LIT_RETURN_LITERAL) begin
				stk.push_back($random(seed) & 13'h1FFF);
				bus(1'b1, OFF_STACK, stk[$], 4'h3);
			end
			run_one({GRP_LITERAL, op, res[7:0]});
			case (op)
				LIT_XOR: begin
					acc = acc ^ res;
					fz = acc == 0;
				end
				LIT_SUBTRACT: begin
					fc = res >= acc;
					fdc = (res & 8'h0F) >= (acc & 8'h0F);
					acc = (res - acc) & 8'hFF;
					fz = acc == 0;
				end
				default: acc = res;
			endcase
			pc = op == LIT_RETURN_LITERAL ? stk.pop_back() : (pc + 1) & 13'h1FFF;
			verify();
		end
		for (int i = 0; i < 10; i++) begin
			w = word_ops[i % 5];
			rand_flags();
			ie_exp = 0;
			load_state();
			k = $random(seed) & 13'h1FFF;
			bus(1'b1, OFF_TPTR, k, 4'h3);
			if (w == OP_RETURN_SUBROUTINE || w == OP_RETURN_INTERRUPT) begin
				stk.push_back($random(seed) & 13'h1FFF);
				bus(1'b1, OFF_STACK, stk[$], 4'h3);
			end
			run_one(w);
			f = u_cie_prog_mem.mem_reg[k];
			if (w == OP_TABLE_READ_LOW)
				acc = f & 8'hFF;
			if (w == OP_TABLE_READ_HIGH)
				acc = f >> 8;
			if (w == OP_RETURN_INTERRUPT)
				ie_exp = 1;
			pc = w == OP_RETURN_SUBROUTINE || w == OP_RETURN_INTERRUPT ? stk.pop_back()
				: (pc + 1) & 13'h1FFF;
			verify();
		end
		run_one(OP_SLEEP);
		idle(4);
		check(32'(SLEEP_ACTIVE), 32'h1);
		pdn = 0;
		bus(1'b1, OFF_CONTROL, 32'h2, 4'h1);
		idle(4);
		check(32'(SLEEP_ACTIVE), 32'h0);
		pc = (pc + 1) & 13'h1FFF;
		verify();
		// store with d clear is not an instruction: no-op, sticky flag, cleared by writing 1
		run_one(16'h0001);
		idle(4);
		bus(1'b0, OFF_STATUS, 32'h0, 4'hF);
		check(rd & 32'h100, 32'h100);
		bus(1'b1, OFF_STATUS, 32'h100, 4'h2);
		pc = (pc + 1) & 13'h1FFF;
		verify();
		RST <= 1'b1;
		repeat (3) @(posedge CLOCK);
		RST <= 1'b0;
		@(posedge CLOCK);
		bus(1'b0, OFF_STATUS, 32'h0, 4'hF);
		check(rd & 32'h1FF, 32'h18);
		bus(1'b0, OFF_ACC, 32'h0, 4'hF);
		check(rd, 32'h0);
		idle(1);
		finish_test();
	end
endmodule : tb_cie_core
